// *** axis_image_exchange.sv ***
/*
 * Holds the backplane data exchange of a four-axis position controller.
 * Assumes the backplane access logic runs on mclk and issues at most one
 * write and one read per file per cycle; status words come from axis logic
 * on the same clock.
 */
`timescale 1ns/100ps
module axis_image_exchange #(
	parameter int AXES = 4
) (
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	input  axis_image_pkg::word_write_t      cmd_wr,
	input  axis_image_pkg::word_read_t       sts_rd,
	input  wire logic [AXES*8*16-1:0]        sts_words,
	input  axis_image_pkg::word_write_t      cfg_wr,
	input  axis_image_pkg::word_write_t      tool_wr,
	input  axis_image_pkg::word_read_t       cfg_rd,
	output logic      [15:0]                 sts_data_reg,
	output logic                             sts_valid_reg,
	output logic      [15:0]                 cfg_data_reg,
	output logic                             cfg_valid_reg,
	output logic      [AXES*8*16-1:0]        cmd_words_reg,
	output logic      [AXES*16*16-1:0]       cfg_words_reg,
	output logic                             cfg_load_reg,
	output logic      [16:0]                 cmd_pos_mag_reg
);
	// Image and file address widths.
	localparam int IAW = axis_image_pkg::IMG_AW;
	localparam int CAW = axis_image_pkg::CFG_AW;

	// Recovers the intended unsigned magnitude of a wrapped signed word.
	function automatic logic [16:0] unwrap(input logic [15:0] w);
		logic [16:0] s;
		s = {w[15], w};
		if (w[15]) begin
			unwrap = 17'(s + axis_image_pkg::WRAP_ADD);
		end else begin
			unwrap = s;
		end
	endfunction

	// Command writes inside the 32-word output image are taken; others ignored.
	wire cmd_hit = cmd_wr.strobe && (cmd_wr.addr[5] == 1'b0);
	// Tool writes win over any host load in the same cycle, whatever word the host addressed.
	wire tool_hit = tool_wr.strobe;
	// Configuration store write selection.
	wire              cfg_we   = cfg_wr.strobe || tool_hit;
	wire [CAW-1:0]    cfg_wa   = tool_hit ? tool_wr.addr : cfg_wr.addr;
	wire [15:0]       cfg_wd   = tool_hit ? tool_wr.data : cfg_wr.data;
	// Status reads inside the 32-word input image.
	wire              sts_hit  = sts_rd.strobe && (sts_rd.addr[5] == 1'b0);
	wire [IAW-1:0]    sts_idx  = sts_rd.addr[IAW-1:0];
	// Position word of axis 1 command group, word 4.
	wire [15:0]       pos_word = cmd_words_reg[4*16 +: 16];

	// Command image store: axis n uses words 8(n-1)..8(n-1)+7.
	axis_word_store #(.DEPTH(32), .AW(IAW)) u_cmd (
		.mclk        (mclk),
		.arst_n      (arst_n),
		.wr_en       (cmd_hit),
		.wr_addr     (cmd_wr.addr[IAW-1:0]),
		.wr_data     (cmd_wr.data),
		.rd_addr     ('0),
		.rd_data_reg (),
		.flat_reg    (cmd_words_reg)
	);

	// One configuration store serves as both the write and readback file.
	axis_word_store #(.DEPTH(64), .AW(CAW)) u_cfg (
		.mclk        (mclk),
		.arst_n      (arst_n),
		.wr_en       (cfg_we),
		.wr_addr     (cfg_wa),
		.wr_data     (cfg_wd),
		.rd_addr     (cfg_rd.addr),
		.rd_data_reg (cfg_data_reg),
		.flat_reg    (cfg_words_reg)
	);

	// Registers status reads, load pulses and the unwrapped position.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sts_data_reg    <= axis_image_pkg::WORD_RST;
			sts_valid_reg   <= 1'b0;
			cfg_valid_reg   <= 1'b0;
			cfg_load_reg    <= 1'b0;
			cmd_pos_mag_reg <= 17'h00000;
		end else begin
			// Status block of axis n sits at words 8(n-1)..8(n-1)+7.
			sts_data_reg    <= sts_hit ? sts_words[sts_idx*16 +: 16] : 16'h0000;
			sts_valid_reg   <= sts_hit;
			cfg_valid_reg   <= cfg_rd.strobe;
			cfg_load_reg    <= cfg_wr.strobe;
			// Host-side wrapping is relied on; magnitude is recovered here.
			cmd_pos_mag_reg <= unwrap(pos_word);
		end
	end

	// Checks on the exchange.
	// Every check samples on the rising clock and rests while reset is held.
	// Each one watches outputs that the block drives, one cycle after the request.

	// A taken command write shows in the flat image one cycle later.
	// The address is the low five bits, since bit five marks a refused write.
	chk_cmd_store : assert property (
		@(posedge mclk) disable iff (!arst_n)
		cmd_hit |=> cmd_words_reg[$past(cmd_wr.addr[4:0])*16 +: 16] == $past(cmd_wr.data))
		else $error("command word not stored");

	// A command write outside the image leaves every command word alone.
	// Axis groups therefore never pick up stray host traffic.
	chk_cmd_ignore : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(cmd_wr.strobe && cmd_wr.addr[5]) |=> $stable(cmd_words_reg))
		else $error("out of range command changed image");

	// An in-range status read answers with the word that stood at the request.
	// The valid pulse and the data appear together.
	chk_sts_read : assert property (
		@(posedge mclk) disable iff (!arst_n)
		sts_hit |=> sts_valid_reg && sts_data_reg == $past(sts_words[sts_idx*16 +: 16]))
		else $error("status word wrong");

	// A status read past the last axis block is never answered.
	// The host sees no valid pulse for it.
	chk_sts_range : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(sts_rd.strobe && sts_rd.addr[5]) |=> !sts_valid_reg)
		else $error("status read outside image answered");

	// Without an in-range read the status output rests at zero.
	// This keeps stale words from looking like fresh answers.
	chk_sts_idle : assert property (
		@(posedge mclk) disable iff (!arst_n)
		!sts_hit |=> (sts_data_reg == 16'h0000) && !sts_valid_reg)
		else $error("status output not idle");

	// A host write with no tool collision, read back at once, returns the written word.
	// Both files share one layout, so the same address finds it.
	chk_cfg_echo : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(cfg_wr.strobe && !tool_hit) ##1 (cfg_rd.strobe && cfg_rd.addr == $past(cfg_wr.addr))
		|=> cfg_data_reg == $past(cfg_wr.data, 2))
		else $error("readback differs from write file");

	// A host configuration write with no tool collision lands in the file.
	// The word sits at the address the host gave.
	chk_cfg_host : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(cfg_wr.strobe && !tool_hit) |=> cfg_words_reg[$past(cfg_wr.addr)*16 +: 16] == $past(cfg_wr.data))
		else $error("host configuration word not stored");

	// Each host configuration write raises the load pulse for one cycle.
	// The pulse rises even when a tool update takes the same word.
	chk_load_pulse : assert property (
		@(posedge mclk) disable iff (!arst_n)
		cfg_wr.strobe |=> cfg_load_reg)
		else $error("load pulse missing");

	// A tool update always lands, also against a host write in the same cycle.
	// The readback file thus shows the tool's latest values.
	chk_tool_update : assert property (
		@(posedge mclk) disable iff (!arst_n)
		tool_hit |=> cfg_words_reg[$past(tool_wr.addr)*16 +: 16] == $past(tool_wr.data))
		else $error("tool update missing");

	// Each readback request is answered by a valid pulse one cycle later.
	// The host takes the word in that cycle.
	chk_cfg_valid : assert property (
		@(posedge mclk) disable iff (!arst_n)
		cfg_rd.strobe |=> cfg_valid_reg)
		else $error("readback valid missing");

	// A wrapped word recovers its magnitude as signed value plus the wrap offset.
	// That equals the word taken as an unsigned count.
	chk_unwrap : assert property (
		@(posedge mclk) disable iff (!arst_n)
		pos_word[15] |=> cmd_pos_mag_reg == {1'b0, $past(pos_word)})
		else $error("wrapped magnitude wrong");

	// A word inside the signed range passes through unchanged.
	// No offset may be added to it.
	chk_direct : assert property (
		@(posedge mclk) disable iff (!arst_n)
		!pos_word[15] |=> cmd_pos_mag_reg == {1'b0, $past(pos_word)})
		else $error("direct value changed");

	// A write to the fourth axis group leaves the first three groups alone.
	// Groups sit one after another in axis order.
	chk_axis_layout : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(cmd_hit && cmd_wr.addr[4:3] == 2'h3) |=> $stable(cmd_words_reg[0 +: 384]))
		else $error("axis four write touched other axes");

	// A configuration write to the first axis leaves the other three axes alone.
	// Each axis owns sixteen words in axis order.
	chk_cfg_layout : assert property (
		@(posedge mclk) disable iff (!arst_n)
		(cfg_we && cfg_wa[5:4] == 2'h0) |=> $stable(cfg_words_reg[1023:256]))
		else $error("axis one write touched other axes");

	// Main scenarios that the bench should reach.
	// Command writes, status reads and tool collisions.
	cov_cmd : cover property (@(posedge mclk) disable iff (!arst_n) cmd_hit);
	cov_sts : cover property (@(posedge mclk) disable iff (!arst_n) sts_hit);
	cov_tool : cover property (@(posedge mclk) disable iff (!arst_n) tool_hit && cfg_wr.strobe);
	// Wrapped magnitudes and the write followed at once by a readback.
	cov_wrap : cover property (@(posedge mclk) disable iff (!arst_n) cmd_pos_mag_reg > 17'h07FFF);
	cov_echo : cover property (@(posedge mclk) disable iff (!arst_n)
		cfg_wr.strobe ##1 (cfg_rd.strobe && cfg_rd.addr == $past(cfg_wr.addr)));
endmodule

// *** axis_image_pkg.sv ***
/*
 * Holds the shared constants and carriers of the axis image exchange block.
 * Assumes a single 125 MHz clock domain and nothing else of its surroundings.
 */
package axis_image_pkg;
	// Number of axes served by the block.
	localparam int AXES          = 4;
	// Width of one image or file word.
	localparam int WORD_W        = 16;
	// Words per axis in the command and status images.
	localparam int IMG_PER_AXIS  = 8;
	// Words per axis in the configuration files.
	localparam int CFG_PER_AXIS  = 16;
	// Total image words in each direction.
	localparam int IMG_WORDS     = AXES * IMG_PER_AXIS;
	// Total words in each configuration file.
	localparam int CFG_WORDS     = AXES * CFG_PER_AXIS;
	// Address widths of the image and the configuration files.
	localparam int IMG_AW        = 5;
	localparam int CFG_AW        = 6;
	// Value of every stored word after reset.
	localparam logic [15:0] WORD_RST = 16'h0000;
	// Largest value that a signed word carries directly.
	localparam logic [16:0] POS_LIMIT = 17'h07FFF;
	// Offset added to a wrapped word to recover its magnitude.
	localparam logic [16:0] WRAP_ADD  = 17'h10000;

	// One backplane write: a strobe, a word address and the data.
	typedef struct packed {
		logic        strobe;
		logic [5:0]  addr;
		logic [15:0] data;
	} word_write_t;

	// One backplane read request: a strobe and a word address.
	typedef struct packed {
		logic       strobe;
		logic [5:0] addr;
	} word_read_t;
endpackage

// *** axis_word_store.sv ***
/*
 * Holds a flip-flop word store with one write port and one registered read port.
 * Assumes write and read requests come from logic on the same clock.
 */
`timescale 1ns/100ps
module axis_word_store #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              wr_en,
	input  wire logic [AW-1:0]     wr_addr,
	input  wire logic [15:0]       wr_data,
	input  wire logic [AW-1:0]     rd_addr,
	output logic      [15:0]       rd_data_reg,
	output logic [DEPTH*16-1:0]    flat_reg
);
	// Storage words, addressed by index.
	logic [15:0] mem_reg [DEPTH];

	// Stores the write and updates the read register every cycle.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= axis_image_pkg::WORD_RST;
			end
			rd_data_reg <= axis_image_pkg::WORD_RST;
		end else begin
			if (wr_en) begin
				mem_reg[wr_addr] <= wr_data;
			end
			rd_data_reg <= mem_reg[rd_addr];
		end
	end

	// Presents every word flat so the core logic can see all axes at once.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			flat_reg[i*16 +: 16] = mem_reg[i];
		end
	end
endmodule

// *** host_wrap_model.sv ***
/*
 * Holds a host-side model that packs a wanted count into a command word.
 * Assumes the host keeps counts between 0 and 65535.
 */
`timescale 1ns/100ps
module host_wrap_model (
	input  wire logic [16:0] want,
	output logic      [15:0] word
);
	// Counts past +32767 wrap to -32768 and climb toward -1 with each further count.
	assign word = want[15:0];
endmodule

// *** testbench.sv ***
/*
 * Holds the self-checking bench of the axis image exchange block.
 * Assumes the package, the block and the host wrap model are compiled first.
 */
`timescale 1ns/100ps
module testbench;
	logic                        mclk;
	logic                        arst_n;
	axis_image_pkg::word_write_t cmd_wr, cfg_wr, tool_wr;
	axis_image_pkg::word_read_t  sts_rd, cfg_rd;
	logic [511:0]                sts_words, cmd_words_reg;
	logic [1023:0]               cfg_words_reg;
	logic [15:0]                 sts_data_reg, cfg_data_reg, host_word;
	logic                        sts_valid_reg, cfg_valid_reg, cfg_load_reg;
	logic [16:0]                 cmd_pos_mag_reg, want;
	logic [15:0]                 exp_word [0:63];
	logic [31:0]                 rng;
	int                          errors, tests_run;
	// Wanted counts around the wrap point and at the top of the range.
	logic [16:0]                 wants [0:5] = '{17'h07FFF, 17'h08000, 17'h08001,
		17'h08002, 17'h09C40, 17'h0FFFF};

	axis_image_exchange #(.AXES(4)) dut (.mclk(mclk), .arst_n(arst_n), .cmd_wr(cmd_wr),
		.sts_rd(sts_rd), .sts_words(sts_words), .cfg_wr(cfg_wr), .tool_wr(tool_wr),
		.cfg_rd(cfg_rd), .sts_data_reg(sts_data_reg), .sts_valid_reg(sts_valid_reg),
		.cfg_data_reg(cfg_data_reg), .cfg_valid_reg(cfg_valid_reg),
		.cmd_words_reg(cmd_words_reg), .cfg_words_reg(cfg_words_reg),
		.cfg_load_reg(cfg_load_reg), .cmd_pos_mag_reg(cmd_pos_mag_reg));
	host_wrap_model host (.want(want), .word(host_word));

	// Steps the xorshift generator once.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Counts a comparison and reports it when it does not hold.
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Makes the 125 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Cuts a hung run short.
	initial begin
		#200000;
		errors++;
		print_verdict();
	end

	// Drives inputs at the falling edge, position writes 1 ns after it, and checks after the rising edge.
	initial begin
		{cmd_wr, cfg_wr, tool_wr, sts_rd, cfg_rd, sts_words, want} = '0;
		arst_n = 1'b0;
		rng = 32'd23297;
		errors = 0;
		tests_run = 0;
		repeat (5) @(negedge mclk);
		arst_n = 1'b1;
		// All command words back to back, then address 32 which must not land.
		for (int k = 0; k < 33; k++) begin
			rng = xs(rng);
			exp_word[k] = rng[15:0];
			cmd_wr = {1'b1, (k == 32) ? 6'h20 : 6'(k), rng[15:0]};
			@(negedge mclk);
		end
		cmd_wr = '0;
		for (int k = 0; k < 32; k++) begin
			check(cmd_words_reg[16*k +: 16] === exp_word[k], "command word");
			rng = xs(rng);
			sts_words[16*k +: 16] = rng[15:0];
		end
		// Every status word back to back, then an out-of-range read.
		for (int k = 0; k < 33; k++) begin
			sts_rd = {1'b1, (k == 32) ? 6'h28 : 6'(k)};
			@(negedge mclk);
			check(sts_valid_reg === (k < 32), "status valid");
			check(sts_data_reg === ((k < 32) ? sts_words[16*k +: 16] : 16'h0000),
				"status data");
		end
		sts_rd = '0;
		// Whole configuration file, with a tool update colliding on word 5.
		for (int k = 0; k < 64; k++) begin
			rng = xs(rng);
			exp_word[k] = (k == 5) ? ~rng[15:0] : rng[15:0];
			cfg_wr = {1'b1, 6'(k), rng[15:0]};
			tool_wr = {(k == 5), 6'(k), ~rng[15:0]};
			@(negedge mclk);
			check((k == 5) || (cfg_load_reg === 1'b1), "load pulse");
		end
		{cfg_wr, tool_wr} = '0;
		for (int k = 0; k < 64; k++) begin
			cfg_rd = {1'b1, 6'(k)};
			@(negedge mclk);
			check(cfg_valid_reg === 1'b1, "readback valid");
			check(cfg_data_reg === exp_word[k], "readback word");
			check(cfg_words_reg[16*k +: 16] === exp_word[k], "stored word");
		end
		// Host write followed at once by a readback of the same word.
		rng = xs(rng);
		cfg_wr = {1'b1, 6'h09, rng[15:0]};
		cfg_rd = '0;
		@(negedge mclk);
		cfg_wr = '0;
		cfg_rd = {1'b1, 6'h09};
		check(cfg_load_reg === 1'b1, "echo load pulse");
		@(negedge mclk);
		check(cfg_data_reg === rng[15:0], "echo word");
		cfg_rd = '0;
		// Axis 1 position words around the wrap point.
		for (int k = 0; k < 6; k++) begin
			want = wants[k];
			#1 cmd_wr = {1'b1, 6'h04, host_word};
			@(negedge mclk);
			cmd_wr = '0;
			@(negedge mclk);
			check(cmd_pos_mag_reg === want, "recovered magnitude");
		end
		print_verdict();
	end
endmodule
